// ==== guard_timer_pkg.sv ====
// Shared constants, field positions and types for the guard timer block.
package guard_timer_pkg;
   // Register bus geometry.
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int REG_W = 8;
   // Register byte addresses.
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h00;
   localparam logic [7:0] ADDR_GUARD_CTRL = 8'h04;
   // Bus response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Control and status register fields.
   localparam int CTRL_IRQ_FLAG = 7;
   localparam int CTRL_IRQ_EN = 6;
   localparam int CTRL_PRESC_TOP = 5;
   localparam int CTRL_CHANGE_EN = 4;
   localparam int CTRL_RESET_EN = 3;
   localparam int CTRL_PRESC_LOW_HI = 2;
   localparam int CTRL_PRESC_LOW_LO = 0;
   // Reset cause register fields; bits from CAUSE_W upward read as zero.
   localparam int CAUSE_POWER_UP = 0;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_SUPPLY_DROP = 2;
   localparam int CAUSE_GUARD = 3;
   localparam int CAUSE_SCAN = 4;
   localparam int CAUSE_BUS_END = 5;
   localparam int CAUSE_W = 6;
   // Prescaler selection and time-out counts in oscillator cycles.
   localparam int PRESC_W = 4;
   localparam logic [3:0] PRESC_RESET = 4'h0;
   localparam logic [3:0] PRESC_MAX_CODE = 4'h9;
   localparam int BASE_CYCLES = 2048;
   localparam int COUNT_W = 21;
   // Oscillator rate and the resulting span of time-outs.
   localparam int OSC_FREQ_HZ = 128000;
   localparam int SHORTEST_TIMEOUT_MS = 16;
   localparam int LONGEST_TIMEOUT_MS = 8000;
   // Length of the change-enable window in system clock cycles.
   localparam int CHANGE_WINDOW_CYCLES = 4;
   localparam int WINDOW_CNT_W = 3;
   // Operating mode, Gray coded along stopped, irq, both, reset.
   typedef enum logic [1:0] {
      MODE_STOPPED = 2'b00,
      MODE_IRQ = 2'b01,
      MODE_BOTH = 2'b11,
      MODE_RESET = 2'b10
   } guard_mode_t;
   // Maps the effective enable bits onto the operating mode.
   function automatic guard_mode_t mode_of(input logic reset_en, input logic irq_en);
      guard_mode_t m;
      m = MODE_STOPPED;
      if (reset_en && irq_en) m = MODE_BOTH;
      else if (reset_en) m = MODE_RESET;
      else if (irq_en) m = MODE_IRQ;
      return m;
   endfunction : mode_of
endpackage : guard_timer_pkg

// ==== guard_timer_counter.sv ====
// Oscillator-driven time-out counter for the guard timer.
`timescale 1ns/1ps
module guard_timer_counter (
   // Clock, reset and freeze.
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   // Oscillator level and control.
   input wire logic i_osc_level,
   input wire logic i_run,
   input wire logic i_restart,
   input wire logic [guard_timer_pkg::PRESC_W-1:0] i_prescale,
   // One-cycle time-out pulse.
   output logic o_timeout
);
   // Previous oscillator level, for rising edge detection.
   logic osc_prev;
   // Oscillator cycles counted since the last restart.
   logic [guard_timer_pkg::COUNT_W-1:0] count;
   // Last count value before a time-out.
   logic [guard_timer_pkg::COUNT_W-1:0] limit;
   logic osc_tick;
   logic at_limit;

   // Reserved codes fall back to the longest period.
   function automatic logic [guard_timer_pkg::COUNT_W-1:0] limit_of(
      input logic [guard_timer_pkg::PRESC_W-1:0] code);
      logic [guard_timer_pkg::PRESC_W-1:0] c;
      c = (code > guard_timer_pkg::PRESC_MAX_CODE) ? guard_timer_pkg::PRESC_MAX_CODE : code;
      return (guard_timer_pkg::COUNT_W'(guard_timer_pkg::BASE_CYCLES) << c)
         - guard_timer_pkg::COUNT_W'(1);
   endfunction : limit_of

   assign limit = limit_of(i_prescale);
   assign osc_tick = i_osc_level & ~osc_prev;
   // A shorter period chosen mid-count expires at once, hence the compare.
   assign at_limit = count >= limit;

   // Samples the oscillator level.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) osc_prev <= 1'b0;
      else if (i_clk_en) osc_prev <= i_osc_level;
   end

   // Counts oscillator cycles, restarting on request or time-out.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         count <= '0;
      end else if (i_clk_en) begin
         if (i_restart || !i_run) count <= '0;
         else if (osc_tick) count <= at_limit ? '0 : count + 1'b1;
      end
   end

   // Raises the time-out for one cycle.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) o_timeout <= 1'b0;
      else if (i_clk_en) o_timeout <= i_run & ~i_restart & osc_tick & at_limit;
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   a_period_hit: assert property ((osc_tick && at_limit && i_run && !i_restart && i_clk_en)
      |=> o_timeout) else $error("time-out missed at limit");
   a_no_early_out: assert property ((i_clk_en && !(osc_tick && at_limit))
      |=> !o_timeout) else $error("time-out before limit");
endmodule : guard_timer_counter

// ==== watchdog_timer_with_reset_flags.sv ====
// Guard timer with reset cause flags behind an AXI4-Lite register slave.
// Function
// - Counter runs on oscillator; time-out fires action.
// - Restart instruction returns counter to start.
// - Reset and irq enables select the mode.
// - Fuse forces reset mode, enables read 1/0.
// - Clearing reset enable or prescale needs window.
// - Change enable self-clears after four cycles.
// - Time-out in irq configuration sets flag.
// - Flag cleared by vector or written one.
// - Interrupt needs global enable, enable, flag.
// - Vector in combined mode clears enable, flag.
// - Unserviced flag plus time-out gives reset.
// - Guard, supply, pin flags: set; cleared.
// - Power-up flag cleared only by writing zero.
// - Scan reset flag set by scan reset.
// - Cause bits seven and six read zero.
// - Time-outs span 16 ms to 8 s.
// - Guard reset flag forces reset enable on.
// - Prescale codes double 2048 up to 1048576.
// - Reset-mode time-out gives one-cycle pulse.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module watchdog_timer_with_reset_flags (
   // Clock, reset and freeze.
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   // Guard timer oscillator, fuse and processor events.
   input wire logic i_guard_osc,
   input wire logic i_guard_always_on_fuse,
   input wire logic i_guard_restart,
   input wire logic i_global_irq_enable,
   input wire logic i_guard_irq_ack,
   // Reset sources recorded in the cause register.
   input wire logic i_power_up_reset,
   input wire logic i_pin_reset,
   input wire logic i_supply_drop_reset,
   input wire logic i_scan_reset,
   input wire logic i_bus_end_reset,
   // AXI4-Lite write address and data.
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [guard_timer_pkg::AXI_ADDR_W-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [guard_timer_pkg::AXI_DATA_W-1:0] i_wdata,
   input wire logic [guard_timer_pkg::AXI_DATA_W/8-1:0] i_wstrb,
   // AXI4-Lite write response.
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // AXI4-Lite read address and data.
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [guard_timer_pkg::AXI_ADDR_W-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [guard_timer_pkg::AXI_DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   // Results towards the processor.
   output logic o_guard_irq_request,
   output logic o_system_reset
);
   // Interrupt flag, set by time-outs.
   logic irq_flag;
   // Stored interrupt enable.
   logic irq_en;
   // Stored reset enable.
   logic reset_en;
   // Prescaler selection.
   logic [guard_timer_pkg::PRESC_W-1:0] presc;
   // Change enable and its remaining lifetime.
   logic change_en;
   logic [guard_timer_pkg::WINDOW_CNT_W-1:0] window_cnt;
   // Reset cause flags.
   logic [guard_timer_pkg::CAUSE_W-1:0] cause;
   // Effective enables after the fuse override.
   logic eff_reset_en;
   logic eff_irq_en;
   guard_timer_pkg::guard_mode_t mode;
   // Counter time-out pulse and derived events.
   logic timeout;
   logic flag_set;
   logic reset_event;
   // Bus handshakes and decoded accesses.
   logic wr_fire;
   logic rd_fire;
   logic wr_ctrl;
   logic wr_cause;
   logic open_fire;
   logic [guard_timer_pkg::REG_W-1:0] wbyte;
   logic [guard_timer_pkg::REG_W-1:0] ctrl_view;
   logic [guard_timer_pkg::CAUSE_W-1:0] cause_set;

   // True when a byte address selects the given register word.
   function automatic logic hits(input logic [guard_timer_pkg::AXI_ADDR_W-1:0] a,
                                 input logic [guard_timer_pkg::AXI_ADDR_W-1:0] base);
      return a[guard_timer_pkg::AXI_ADDR_W-1:2] == base[guard_timer_pkg::AXI_ADDR_W-1:2];
   endfunction : hits

   // The fuse pins reset enable high and interrupt enable low.
   assign eff_reset_en = reset_en | i_guard_always_on_fuse;
   assign eff_irq_en = irq_en & ~i_guard_always_on_fuse;
   assign mode = guard_timer_pkg::mode_of(eff_reset_en, eff_irq_en);

   // Counts oscillator cycles while the mode is not stopped.
   guard_timer_counter u_counter (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_clk_en(i_clk_en),
      .i_osc_level(i_guard_osc),
      .i_run(mode != guard_timer_pkg::MODE_STOPPED),
      .i_restart(i_guard_restart),
      .i_prescale(presc),
      .o_timeout(timeout)
   );

   // Time-out in irq mode, or first one in combined mode, raises the flag.
   assign flag_set = timeout & ((mode == guard_timer_pkg::MODE_IRQ) |
      ((mode == guard_timer_pkg::MODE_BOTH) & ~irq_flag));
   // Reset mode, or combined mode with the flag still pending, resets.
   assign reset_event = timeout & ((mode == guard_timer_pkg::MODE_RESET) |
      ((mode == guard_timer_pkg::MODE_BOTH) & irq_flag));

   // Request reaches the core only with all three conditions met.
   assign o_guard_irq_request = irq_flag & eff_irq_en & i_global_irq_enable;

   // Both write channels are taken together once no response is owed.
   assign o_awready = i_awvalid & i_wvalid & ~o_bvalid & i_clk_en;
   assign o_wready = o_awready;
   assign wr_fire = o_awready;
   assign o_arready = ~o_rvalid & i_clk_en;
   assign rd_fire = i_arvalid & o_arready;
   assign wbyte = i_wdata[guard_timer_pkg::REG_W-1:0];
   assign wr_ctrl = wr_fire & i_wstrb[0] & hits(i_awaddr, guard_timer_pkg::ADDR_GUARD_CTRL);
   assign wr_cause = wr_fire & i_wstrb[0] & hits(i_awaddr, guard_timer_pkg::ADDR_RESET_CAUSE);
   // Opening write carries ones in both change enable and reset enable.
   assign open_fire = wr_ctrl & wbyte[guard_timer_pkg::CTRL_CHANGE_EN]
      & wbyte[guard_timer_pkg::CTRL_RESET_EN];

   // Readback of the control register shows effective enables.
   always_comb begin
      ctrl_view = '0;
      ctrl_view[guard_timer_pkg::CTRL_IRQ_FLAG] = irq_flag;
      ctrl_view[guard_timer_pkg::CTRL_IRQ_EN] = eff_irq_en;
      ctrl_view[guard_timer_pkg::CTRL_PRESC_TOP] = presc[guard_timer_pkg::PRESC_W-1];
      ctrl_view[guard_timer_pkg::CTRL_CHANGE_EN] = change_en;
      ctrl_view[guard_timer_pkg::CTRL_RESET_EN] = eff_reset_en;
      ctrl_view[guard_timer_pkg::CTRL_PRESC_LOW_HI:guard_timer_pkg::CTRL_PRESC_LOW_LO] =
         presc[guard_timer_pkg::PRESC_W-2:0];
   end

   // Write response: OKAY for the two registers, SLVERR elsewhere.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_bvalid <= 1'b0;
         o_bresp <= guard_timer_pkg::RESP_OKAY;
      end else if (i_clk_en) begin
         if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= (hits(i_awaddr, guard_timer_pkg::ADDR_GUARD_CTRL) ||
                        hits(i_awaddr, guard_timer_pkg::ADDR_RESET_CAUSE)) ?
                       guard_timer_pkg::RESP_OKAY : guard_timer_pkg::RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // Read data is captured at the same edge that takes the address.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= guard_timer_pkg::RESP_OKAY;
      end else if (i_clk_en) begin
         if (rd_fire) begin
            o_rvalid <= 1'b1;
            o_rresp <= guard_timer_pkg::RESP_OKAY;
            o_rdata <= '0;
            if (hits(i_araddr, guard_timer_pkg::ADDR_GUARD_CTRL)) begin
               o_rdata[guard_timer_pkg::REG_W-1:0] <= ctrl_view;
            end else if (hits(i_araddr, guard_timer_pkg::ADDR_RESET_CAUSE)) begin
               // Upper cause bits stay zero.
               o_rdata[guard_timer_pkg::CAUSE_W-1:0] <= cause;
            end else begin
               o_rresp <= guard_timer_pkg::RESP_SLVERR;
            end
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // Interrupt flag: a flag-setting time-out wins over any clear.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) irq_flag <= 1'b0;
      else if (i_clk_en) begin
         if (flag_set) irq_flag <= 1'b1;
         else if (i_guard_irq_ack || (wr_ctrl && wbyte[guard_timer_pkg::CTRL_IRQ_FLAG]))
            irq_flag <= 1'b0;
      end
   end

   // Interrupt enable: a software write wins over the vector's clear.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) irq_en <= 1'b0;
      else if (i_clk_en) begin
         if (wr_ctrl) irq_en <= wbyte[guard_timer_pkg::CTRL_IRQ_EN];
         else if (i_guard_irq_ack && mode == guard_timer_pkg::MODE_BOTH)
            irq_en <= 1'b0;
      end
   end

   // Reset enable: set freely, cleared only inside the change window.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) reset_en <= 1'b0;
      else if (i_clk_en) begin
         if (cause[guard_timer_pkg::CAUSE_GUARD]) reset_en <= 1'b1;
         else if (wr_ctrl && wbyte[guard_timer_pkg::CTRL_RESET_EN]) reset_en <= 1'b1;
         else if (wr_ctrl && change_en) reset_en <= 1'b0;
      end
   end

   // Prescaler: only a write inside the change window alters it.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) presc <= guard_timer_pkg::PRESC_RESET;
      else if (i_clk_en && wr_ctrl && change_en && !open_fire)
         presc <= {wbyte[guard_timer_pkg::CTRL_PRESC_TOP],
                   wbyte[guard_timer_pkg::CTRL_PRESC_LOW_HI:guard_timer_pkg::CTRL_PRESC_LOW_LO]};
   end

   // Change window: opened by the pair of ones, closed after four cycles.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         change_en <= 1'b0;
         window_cnt <= '0;
      end else if (i_clk_en) begin
         if (open_fire) begin
            change_en <= 1'b1;
            window_cnt <= guard_timer_pkg::WINDOW_CNT_W'(guard_timer_pkg::CHANGE_WINDOW_CYCLES);
         end else if (wr_ctrl && change_en) begin
            // The applying write uses up the window.
            change_en <= 1'b0;
            window_cnt <= '0;
         end else if (window_cnt != '0) begin
            window_cnt <= window_cnt - 1'b1;
            if (window_cnt == guard_timer_pkg::WINDOW_CNT_W'(1)) change_en <= 1'b0;
         end
      end
   end

   // One-cycle system reset pulse on a reset-mode time-out.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) o_system_reset <= 1'b0;
      else if (i_clk_en) o_system_reset <= reset_event;
   end

   // Set sources for each cause flag, in bit order.
   assign cause_set = {i_bus_end_reset, i_scan_reset, reset_event,
                       i_supply_drop_reset, i_pin_reset, i_power_up_reset};

   // Cause flags survive block resets; power-up clears all but its own.
   // Setting wins over a written zero or a power-up clear.
   for (genvar i = 0; i < guard_timer_pkg::CAUSE_W; i++) begin : g_cause
      always_ff @(posedge i_ref_clk) begin
         if (i_clk_en) begin
            if (cause_set[i]) cause[i] <= 1'b1;
            else if (i_power_up_reset && i != guard_timer_pkg::CAUSE_POWER_UP)
               cause[i] <= 1'b0;
            else if (wr_cause && !wbyte[i]) cause[i] <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   a_reset_pulse_one: assert property ((o_system_reset && i_clk_en) |=> !o_system_reset)
      else $error("system reset longer than one cycle");
   a_reset_mode_out: assert property ((timeout && i_clk_en && mode == guard_timer_pkg::MODE_RESET)
      |=> o_system_reset && cause[guard_timer_pkg::CAUSE_GUARD])
      else $error("reset-mode time-out gave no reset");
   a_fuse_locks_mode: assert property (i_guard_always_on_fuse
      |-> mode == guard_timer_pkg::MODE_RESET && !o_guard_irq_request)
      else $error("fuse did not force reset mode");
   a_presc_locked: assert property ((!change_en && i_clk_en) |=> $stable(presc))
      else $error("prescaler changed outside window");
   a_reset_en_locked: assert property ((reset_en && !change_en) |=> reset_en)
      else $error("reset enable cleared outside window");
   a_window_closes: assert property (open_fire ##1 i_clk_en [*4] |=> !change_en)
      else $error("change enable outlived four cycles");
   a_window_opens: assert property (open_fire |=> change_en && reset_en)
      else $error("opening write did not open window");
   a_flag_on_timeout: assert property ((timeout && i_clk_en && mode == guard_timer_pkg::MODE_IRQ)
      |=> irq_flag) else $error("time-out did not set flag");
   a_ack_clears_flag: assert property ((i_guard_irq_ack && i_clk_en && !flag_set) |=> !irq_flag)
      else $error("vector did not clear flag");
   a_both_to_reset: assert property ((i_guard_irq_ack && i_clk_en && !timeout && !wr_ctrl
      && mode == guard_timer_pkg::MODE_BOTH) |=> mode == guard_timer_pkg::MODE_RESET)
      else $error("combined mode did not fall to reset mode");
   a_second_timeout: assert property ((timeout && i_clk_en && irq_flag
      && mode == guard_timer_pkg::MODE_BOTH) |=> o_system_reset)
      else $error("unserviced flag did not reset");
   a_irq_gate: assert property ((irq_flag && eff_irq_en && !i_global_irq_enable)
      |-> !o_guard_irq_request) else $error("request without global enable");
   a_restart_quiet: assert property ((i_guard_restart && i_clk_en) |=> !timeout)
      else $error("time-out right after restart");
   a_flag_forces_en: assert property ((cause[guard_timer_pkg::CAUSE_GUARD] && i_clk_en)
      |=> reset_en) else $error("guard flag did not force reset enable");
   a_power_up_flag: assert property ((i_power_up_reset && i_clk_en)
      |=> cause[guard_timer_pkg::CAUSE_POWER_UP]) else $error("power-up flag not set");
   a_scan_flag: assert property ((i_scan_reset && i_clk_en) |=> cause[guard_timer_pkg::CAUSE_SCAN])
      else $error("scan flag not set");
   a_pin_flag: assert property ((i_pin_reset && i_clk_en) |=> cause[guard_timer_pkg::CAUSE_PIN])
      else $error("pin flag not set");
   a_bus_end_flag: assert property ((i_bus_end_reset && i_clk_en)
      |=> cause[guard_timer_pkg::CAUSE_BUS_END]) else $error("bus end flag not set");
   a_reserved_zero: assert property ((rd_fire
      && hits(i_araddr, guard_timer_pkg::ADDR_RESET_CAUSE))
      |=> o_rdata[guard_timer_pkg::REG_W-1:guard_timer_pkg::CAUSE_W] == '0)
      else $error("reserved cause bits not zero");

   c_irq_timeout: cover property (timeout && mode == guard_timer_pkg::MODE_IRQ);
   c_reset_pulse: cover property (o_system_reset);
   c_presc_change: cover property (open_fire ##[1:4] (wr_ctrl && change_en));
   c_both_ack: cover property (i_guard_irq_ack && mode == guard_timer_pkg::MODE_BOTH);
endmodule : watchdog_timer_with_reset_flags

// ==== tb_top.sv ====
// Self-checking bench for the guard timer with reset cause flags.
`timescale 1ns/1ps
`define CHK(nm, ex, got) check_val(nm, ex, got)
module tb_top;
   // Clock, reset, oscillator and processor-side inputs.
   logic clk = 0, rst = 1, osc = 0, fuse = 0, gie = 1, ack = 0, restart = 0, cen = 1;
   // Reset sources: power-up, pin, supply drop, scan, bus end.
   logic [4:0] cause_in = 5'h00;
   // Register bus master state.
   logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, lfsr = 8'h61;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, irq_req, sys_rst;
   int n_mismatch = 0, check_count = 0, n, code;
   localparam logic [7:0] CT = guard_timer_pkg::ADDR_GUARD_CTRL;
   localparam logic [7:0] CA = guard_timer_pkg::ADDR_RESET_CAUSE;
   watchdog_timer_with_reset_flags u_dut (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(cen),
      .i_guard_osc(osc), .i_guard_always_on_fuse(fuse), .i_guard_restart(restart),
      .i_global_irq_enable(gie), .i_guard_irq_ack(ack), .i_power_up_reset(cause_in[0]),
      .i_pin_reset(cause_in[1]), .i_supply_drop_reset(cause_in[2]),
      .i_scan_reset(cause_in[3]), .i_bus_end_reset(cause_in[4]), .i_awvalid(awv),
      .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wready),
      .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arv), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
      .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .o_guard_irq_request(irq_req),
      .o_system_reset(sys_rst));
   // System clock of 200 MHz.
   initial forever #2.5 clk = ~clk;
   // The oscillator toggles every system cycle so time-outs stay short.
   always @(posedge clk) osc <= ~osc;
   // Pseudo-random source stepped once per use.
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   // Expected control word; change enable always reads back as zero here.
   function automatic logic [7:0] ctrl_val(input logic f, e, input logic [3:0] p, input logic re);
      return {f, e, p[3], 1'b0, re, p[2:0]};
   endfunction : ctrl_val
   // Register bit recorded for each reset source index.
   function automatic logic [7:0] cause_bit(input int i);
      return 8'h01 << ((i < 3) ? i : i + 1);
   endfunction : cause_bit
   // Counts a comparison and reports a mismatch at once.
   task automatic check_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : check_val
   // One write; request held until taken, response awaited with bready high.
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
      awaddr <= a;
      wdata <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
      @(posedge clk);
      awv <= 1'b0;
      wv <= 1'b0;
      bready <= 1'b1;
      do @(negedge clk); while (bvalid !== 1'b1);
      rs = bresp;
      @(posedge clk);
   endtask : axi_wr
   // One read; data and response taken at the edge where rvalid is seen.
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      araddr <= a;
      arv <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arv <= 1'b0;
      rready <= 1'b1;
      do @(negedge clk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      @(posedge clk);
   endtask : axi_rd
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // Cuts a hang short well after the expected run length.
   initial begin
      #(60000 * 5);
      n_mismatch++;
      wrap_up();
   end
   // Main sequence: cause flags, bus errors, change window, time-outs.
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         cause_in <= 5'h01 << i;
         @(posedge clk);
         cause_in <= 5'h00;
         @(posedge clk);
         axi_rd(CA, d, r);
         // Every source pulsed so far, without the guard bit that none of them sets.
         `CHK("cause flags", (cause_bit(i + 1) - 1) & 8'h37, d);
      end
      axi_wr(CA, 8'hc0, r);
      `CHK("write resp", guard_timer_pkg::RESP_OKAY, r);
      axi_rd(CA, d, r);
      `CHK("cause cleared", 32'h0, d);
      lfsr = lfsr_next(lfsr);
      axi_rd({1'b1, lfsr[4:0], 2'b00}, d, r);
      `CHK("unmapped resp", guard_timer_pkg::RESP_SLVERR, r);
      axi_wr(CT, 8'h08, r);
      axi_wr(CT, 8'h00, r);
      axi_rd(CT, d, r);
      `CHK("enable clear refused", ctrl_val(0, 0, 4'h0, 1), d);
      lfsr = lfsr_next(lfsr);
      code = lfsr % 10;
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      axi_wr(CT, 8'h18, r);
      // A frozen clock enable must also hold the change window open.
      cen <= 1'b0;
      repeat (8) @(posedge clk);
      cen <= 1'b1;
      axi_wr(CT, ctrl_val(0, 0, code[3:0], 0), r);
      axi_rd(CT, d, r);
      `CHK("window applied", ctrl_val(0, 0, code[3:0], 0), d);
      axi_wr(CT, 8'h18, r);
      repeat (6) @(posedge clk);
      axi_wr(CT, 8'h00, r);
      axi_rd(CT, d, r);
      `CHK("window expired", ctrl_val(0, 0, code[3:0], 1), d);
      axi_wr(CT, 8'h18, r);
      axi_wr(CT, 8'h40, r);
      for (n = 0; n < 12000 && irq_req !== 1'b1; n++) @(negedge clk);
      `CHK("irq request", 1'b1, irq_req);
      @(posedge clk);
      gie <= 1'b0;
      @(negedge clk);
      `CHK("irq masked", 1'b0, irq_req);
      @(posedge clk);
      gie <= 1'b1;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      axi_rd(CT, d, r);
      `CHK("ack clears flag", ctrl_val(0, 1, 4'h0, 0), d);
      // A restart midway must push the next time-out a full period away.
      repeat (2000) @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      for (n = 0; n < 12000 && irq_req !== 1'b1; n++) @(negedge clk);
      `CHK("restart delays", 1'b1, n > 2 * guard_timer_pkg::BASE_CYCLES - 8);
      `CHK("irq after restart", 1'b1, irq_req);
      @(posedge clk);
      axi_wr(CT, 8'hc0, r);
      axi_rd(CT, d, r);
      `CHK("write one clears", ctrl_val(0, 1, 4'h0, 0), d);
      // Combined mode: the vector falls back to reset mode; re-armed, then left unserviced.
      axi_wr(CT, 8'h48, r);
      for (n = 0; n < 12000 && irq_req !== 1'b1; n++) @(negedge clk);
      `CHK("combined irq", 1'b1, irq_req);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      axi_rd(CT, d, r);
      `CHK("vector to reset mode", ctrl_val(0, 0, 4'h0, 1), d);
      axi_wr(CT, 8'h48, r);
      for (n = 0; n < 12000 && irq_req !== 1'b1; n++) @(negedge clk);
      for (n = 0; n < 12000 && sys_rst !== 1'b1; n++) @(negedge clk);
      `CHK("unserviced reset", 1'b1, sys_rst);
      @(posedge clk);
      axi_wr(CT, 8'hc0, r);
      axi_wr(CA, 8'h00, r);
      fuse <= 1'b1;
      for (n = 0; n < 12000 && sys_rst !== 1'b1; n++) @(negedge clk);
      `CHK("system reset", 1'b1, sys_rst);
      @(negedge clk);
      `CHK("reset pulse width", 1'b0, sys_rst);
      @(posedge clk);
      axi_rd(CA, d, r);
      `CHK("guard cause", 32'h08, d);
      axi_rd(CT, d, r);
      `CHK("fuse forced bits", ctrl_val(0, 0, 4'h0, 1), d);
      wrap_up();
   end
endmodule : tb_top
